// ---- inc/tcpu_pkg.sv ----
// Package for the timer, counter and PWM unit: offsets, fields, types
package tcpu_pkg;

    // Avalon-MM slave geometry (byte address, word per register)
    localparam int          AVS_ADDR_W     = 10;
    localparam int          AVS_DATA_W     = 32;
    localparam int          AVS_BE_W       = 4;
    localparam int          REG_W          = 8;

    // Register indices; byte address is four times the index
    localparam logic [7:0]  IDX_LEG_CTRL   = 8'h88;
    localparam logic [7:0]  IDX_LEG_MODE   = 8'h89;
    localparam logic [7:0]  IDX_A_LOW      = 8'h8A;
    localparam logic [7:0]  IDX_B_LOW      = 8'h8B;
    localparam logic [7:0]  IDX_A_HIGH     = 8'h8C;
    localparam logic [7:0]  IDX_B_HIGH     = 8'h8D;
    localparam logic [7:0]  IDX_CLK_RATE   = 8'h8E;
    localparam logic [7:0]  IDX_PWM_FLAGS  = 8'h91;
    localparam logic [7:0]  IDX_PWM_CTRL   = 8'hA9;
    localparam logic [7:0]  IDX_B_PRE      = 8'hAA;
    localparam logic [7:0]  IDX_C_PRE      = 8'hAB;
    localparam logic [7:0]  IDX_B_DUTY     = 8'hAC;
    localparam logic [7:0]  IDX_C_DUTY     = 8'hAD;

    // Legacy control fields
    localparam int          LC_RUN_A       = 4;
    localparam int          LC_OVF_A       = 5;
    localparam int          LC_RUN_B       = 6;
    localparam int          LC_OVF_B       = 7;
    // Legacy mode fields, nibble per timer (a low, b high)
    localparam int          LM_MODE_LSB    = 0;
    localparam int          LM_CT          = 2;
    localparam int          LM_GATE        = 3;
    localparam int          LM_B_OFS       = 4;
    // Clock rate control fields
    localparam int          CR_SEL_A       = 3;
    localparam int          CR_SEL_B       = 4;
    localparam logic [2:0]  CR_STRETCH_RST = 3'h1;
    // PWM control fields
    localparam int          PC_B_MODE      = 0;
    localparam int          PC_B_RUN       = 1;
    localparam int          PC_C_MODE      = 2;
    localparam int          PC_C_RUN       = 3;
    localparam logic [7:0]  PC_WR_MASK     = 8'h0F;
    // PWM flag fields
    localparam int          PF_B           = 0;
    localparam int          PF_C           = 1;

    // Timing
    localparam logic [3:0]  DIV12_LAST     = 4'hB;
    localparam logic [1:0]  DIV4_LAST      = 2'h3;
    localparam logic [7:0]  SUBSTEP_LAST   = 8'hFE;

    typedef enum logic [1:0] {
        LM_13BIT   = 2'b00,
        LM_16BIT   = 2'b01,
        LM_RELOAD8 = 2'b10,
        LM_SPLIT   = 2'b11
    } tcpu_lmode_t;

    typedef struct packed {
        logic                    read;
        logic                    write;
        logic [AVS_ADDR_W-1:0]   address;
        logic [AVS_DATA_W-1:0]   writedata;
        logic [AVS_BE_W-1:0]     byteenable;
    } tcpu_avs_req_t;

    typedef struct packed {
        logic [1:0]              level;
        logic [1:0]              oe;
    } tcpu_pwm_pins_t;

endpackage : tcpu_pkg

// ---- src/tcpu_timer_pwm.sv ----
// Two legacy timer/counters and two PWM-capable down timers with Avalon slave

// Notes on behaviour
// - Mode 1 counts sixteen bits, overflow past FFFF
// - Rollover to zero sets overflow flag
// - Count only ungated or gate pin deasserted
// - Mode 2 eight-bit low byte, reload from high
// - Timer a mode 3 splits; b mode 3 holds
// - Split low byte uses timer a controls
// - Split high byte timer-only, b run, b flag
// - Split: timer b runs by mode field
// - Split: timer b sources and gate still work
// - Each PWM timer has mode and run bits
// - Run cleared stops counter; timer mode preloads, PWM mode clears it
// - PWM mode forces pin to output
// - Sixteen-bit down counter, not readable
// - Reload is prescale high, low byte low
// - Underflow reloads and sets request flag
// - Interval is 255 clocks per count step
// - First interrupt one full interval after start
// - PWM mode never raises request
// - PWM period 255 times prescale plus one
// - Duty byte sets high time, zero low
// - Timer b on port bit 4, c bit 5
module tcpu_timer_pwm (
    // Clock and reset
    input  wire logic                   i_mclk,
    input  wire logic                   i_nrst,
    // Avalon-MM register slave
    input  wire tcpu_pkg::tcpu_avs_req_t i_avs,
    output logic [31:0]                 o_avs_readdata,
    output logic                        o_avs_waitrequest,
    // Asynchronous pins
    input  wire logic                   i_legacy_timer_a_count_input,
    input  wire logic                   i_legacy_timer_b_count_input,
    input  wire logic                   i_external_interrupt_a_pin_n,
    input  wire logic                   i_external_interrupt_b_pin_n,
    // Port three direction bits 4 and 5
    input  wire logic [1:0]             i_port_three_direction,
    // Pin drive and status
    output tcpu_pkg::tcpu_pwm_pins_t    o_pwm_pins,
    output logic [1:0]                  o_legacy_overflow_flags,
    output logic [1:0]                  o_pwm_interrupt_request,
    output logic                        o_baud_tick
);
    import tcpu_pkg::*;

    // ---------------- Bus slave state ----------------
    logic                ack_ff;
    logic                nxt_ack;
    logic [31:0]         rdata_ff;
    logic [31:0]         nxt_rdata;
    logic [7:0]          idx;
    logic                wr_go;
    logic [7:0]          wbyte;

    // ---------------- Pin synchronisers ----------------
    logic [3:0]          pin_raw;
    logic [3:0]          sync1_ff;
    logic [3:0]          sync2_ff;
    logic [3:0]          sync3_ff;
    logic [1:0]          fall_edge;

    // ---------------- Legacy timer state ----------------
    logic [3:0]          div_ff;
    logic [3:0]          nxt_div;
    logic [7:0]          lctrl_ff;
    logic [7:0]          nxt_lctrl;
    logic [7:0]          lmode_ff;
    logic [7:0]          nxt_lmode;
    logic [4:0]          crate_ff;
    logic [4:0]          nxt_crate;
    logic [7:0]          a_lo_ff;
    logic [7:0]          a_hi_ff;
    logic [7:0]          b_lo_ff;
    logic [7:0]          b_hi_ff;
    logic [7:0]          nxt_a_lo;
    logic [7:0]          nxt_a_hi;
    logic [7:0]          nxt_b_lo;
    logic [7:0]          nxt_b_hi;
    logic                baud_ff;
    logic                nxt_baud;

    // ---------------- PWM timer state ----------------
    logic [3:0]          pctrl_ff;
    logic [3:0]          nxt_pctrl;
    logic [7:0]          pre_ff   [2];
    logic [7:0]          duty_ff  [2];
    logic [7:0]          nxt_pre  [2];
    logic [7:0]          nxt_duty [2];
    logic [7:0]          sub_ff   [2];
    logic [7:0]          nxt_sub  [2];
    logic [15:0]         cnt_ff   [2];
    logic [15:0]         nxt_cnt  [2];
    logic [1:0]          req_ff;
    logic [1:0]          nxt_req;
    logic [1:0]          lvl_ff;
    logic [1:0]          nxt_lvl;
    logic [1:0]          oe_ff;
    logic [1:0]          nxt_oe;

    // Increment one legacy counter: {overflow, high, low}
    function automatic logic [16:0] f_step(
        input tcpu_lmode_t m,
        input logic [7:0]  lo,
        input logic [7:0]  hi
    );
        logic [16:0] r;
        logic [12:0] c13;
        logic [12:0] c13p;
        logic [15:0] c16p;
        c13  = {hi, lo[4:0]};
        c13p = c13 + 13'h1;
        c16p = {hi, lo} + 16'h1;
        unique case (m)
            LM_13BIT: begin
                // Upper three low-byte bits are left alone
                r = {&c13, c13p[12:5], lo[7:5], c13p[4:0]};
            end
            LM_16BIT: begin
                r = {&{hi, lo}, c16p};
            end
            LM_RELOAD8: begin
                r = {&lo, hi, (&lo) ? hi : lo + 8'h1};
            end
            LM_SPLIT: begin
                r = {&lo, hi, lo + 8'h1};
            end
        endcase
        return r;
    endfunction : f_step

    // ---------------- Bus slave ----------------
    // One wait state per access so read data can come from a flop
    assign idx               = i_avs.address[AVS_ADDR_W-1:2];
    assign o_avs_waitrequest = (i_avs.read | i_avs.write) & ~ack_ff;
    assign wr_go             = i_avs.write & ack_ff & i_avs.byteenable[0];
    assign wbyte             = i_avs.writedata[REG_W-1:0];
    assign o_avs_readdata    = rdata_ff;

    always_comb begin
        nxt_ack   = (i_avs.read | i_avs.write) & ~ack_ff;
        nxt_rdata = rdata_ff;
        if (i_avs.read && !ack_ff) begin
            nxt_rdata = '0;
            unique case (idx)
                IDX_LEG_CTRL:  nxt_rdata[7:0] = lctrl_ff;
                IDX_LEG_MODE:  nxt_rdata[7:0] = lmode_ff;
                IDX_A_LOW:     nxt_rdata[7:0] = a_lo_ff;
                IDX_B_LOW:     nxt_rdata[7:0] = b_lo_ff;
                IDX_A_HIGH:    nxt_rdata[7:0] = a_hi_ff;
                IDX_B_HIGH:    nxt_rdata[7:0] = b_hi_ff;
                IDX_CLK_RATE:  nxt_rdata[4:0] = crate_ff;
                IDX_PWM_FLAGS: nxt_rdata[1:0] = req_ff;
                IDX_PWM_CTRL:  nxt_rdata[3:0] = pctrl_ff;
                IDX_B_PRE:     nxt_rdata[7:0] = pre_ff[0];
                IDX_C_PRE:     nxt_rdata[7:0] = pre_ff[1];
                IDX_B_DUTY:    nxt_rdata[7:0] = duty_ff[0];
                IDX_C_DUTY:    nxt_rdata[7:0] = duty_ff[1];
                default:       nxt_rdata      = '0;
            endcase
        end
    end

    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            ack_ff   <= 1'b0;
            rdata_ff <= '0;
        end else begin
            ack_ff   <= nxt_ack;
            rdata_ff <= nxt_rdata;
        end
    end

    // ---------------- Pin synchronisers ----------------
    assign pin_raw = {i_external_interrupt_b_pin_n,
                      i_external_interrupt_a_pin_n,
                      i_legacy_timer_b_count_input,
                      i_legacy_timer_a_count_input};
    // Edges are taken between second and third stage, never the first
    assign fall_edge = sync3_ff[1:0] & ~sync2_ff[1:0];

    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            sync1_ff <= 4'hF;
            sync2_ff <= 4'hF;
            sync3_ff <= 4'hF;
        end else begin
            sync1_ff <= pin_raw;
            sync2_ff <= sync1_ff;
            sync3_ff <= sync2_ff;
        end
    end

    // ---------------- Legacy timers ----------------
    always_comb begin
        tcpu_lmode_t mode_a;
        tcpu_lmode_t mode_b;
        logic        tick4;
        logic        tick12;
        logic        src_a;
        logic        src_b;
        logic        gate_a;
        logic        gate_b;
        logic        en_a;
        logic        en_b;
        logic        en_hi;
        logic        set_a;
        logic        set_b;
        logic [16:0] st_a;
        logic [16:0] st_b;
        logic [8:0]  hi_p;
        en_b   = 1'b0;
        mode_a = tcpu_lmode_t'(lmode_ff[LM_MODE_LSB +: 2]);
        mode_b = tcpu_lmode_t'(lmode_ff[LM_B_OFS + LM_MODE_LSB +: 2]);
        tick12 = (div_ff == DIV12_LAST);
        tick4  = (div_ff[1:0] == DIV4_LAST);
        nxt_div = tick12 ? '0 : div_ff + 4'h1;

        src_a = lmode_ff[LM_CT] ? fall_edge[0]
              : (crate_ff[CR_SEL_A] ? tick4 : tick12);
        src_b = lmode_ff[LM_B_OFS + LM_CT] ? fall_edge[1]
              : (crate_ff[CR_SEL_B] ? tick4 : tick12);
        // Gate pins are active low: high means deasserted
        gate_a = ~lmode_ff[LM_GATE] | sync2_ff[2];
        gate_b = ~lmode_ff[LM_B_OFS + LM_GATE] | sync2_ff[3];

        en_a  = lctrl_ff[LC_RUN_A] & gate_a & src_a;
        // Split high byte: timer clock only, borrowed run bit
        en_hi = (mode_a == LM_SPLIT) & lctrl_ff[LC_RUN_B]
              & (crate_ff[CR_SEL_B] ? tick4 : tick12);
        if (mode_a == LM_SPLIT) begin
            en_b = (mode_b != LM_SPLIT) & gate_b & src_b;
        end else begin
            en_b = lctrl_ff[LC_RUN_B] & (mode_b != LM_SPLIT)
                 & gate_b & src_b;
        end
        st_a = f_step(mode_a, a_lo_ff, a_hi_ff);
        st_b = f_step(mode_b, b_lo_ff, b_hi_ff);
        hi_p = {1'b0, a_hi_ff} + 9'h1;

        nxt_a_lo = en_a ? st_a[7:0] : a_lo_ff;
        nxt_a_hi = a_hi_ff;
        if (mode_a == LM_SPLIT) begin
            nxt_a_hi = en_hi ? hi_p[7:0] : a_hi_ff;
        end else if (en_a) begin
            nxt_a_hi = st_a[15:8];
        end
        nxt_b_lo = en_b ? st_b[7:0]  : b_lo_ff;
        nxt_b_hi = en_b ? st_b[15:8] : b_hi_ff;
        set_a = en_a & st_a[16];
        // Split mode hands the timer b flag to the high byte
        set_b = (mode_a == LM_SPLIT) ? (en_hi & hi_p[8])
                                     : (en_b & st_b[16]);
        nxt_baud = en_b & st_b[16];
        nxt_lctrl = lctrl_ff;
        nxt_lmode = lmode_ff;
        nxt_crate = crate_ff;
        if (wr_go) begin
            unique case (idx)
                IDX_LEG_CTRL: nxt_lctrl = wbyte;
                IDX_LEG_MODE: nxt_lmode = wbyte;
                IDX_A_LOW:    nxt_a_lo  = wbyte;
                IDX_B_LOW:    nxt_b_lo  = wbyte;
                IDX_A_HIGH:   nxt_a_hi  = wbyte;
                IDX_B_HIGH:   nxt_b_hi  = wbyte;
                IDX_CLK_RATE: nxt_crate = wbyte[4:0];
                default: ;
            endcase
        end
        // A hardware set beats a simultaneous software clear
        nxt_lctrl[LC_OVF_A] = nxt_lctrl[LC_OVF_A] | set_a;
        nxt_lctrl[LC_OVF_B] = nxt_lctrl[LC_OVF_B] | set_b;
    end

    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            div_ff   <= '0;
            lctrl_ff <= '0;
            lmode_ff <= '0;
            crate_ff <= {2'h0, CR_STRETCH_RST};
            a_lo_ff  <= '0;
            a_hi_ff  <= '0;
            b_lo_ff  <= '0;
            b_hi_ff  <= '0;
            baud_ff  <= 1'b0;
        end else begin
            div_ff   <= nxt_div;
            lctrl_ff <= nxt_lctrl;
            lmode_ff <= nxt_lmode;
            crate_ff <= nxt_crate;
            a_lo_ff  <= nxt_a_lo;
            a_hi_ff  <= nxt_a_hi;
            b_lo_ff  <= nxt_b_lo;
            b_hi_ff  <= nxt_b_hi;
            baud_ff  <= nxt_baud;
        end
    end

    assign o_legacy_overflow_flags = {lctrl_ff[LC_OVF_B], lctrl_ff[LC_OVF_A]};
    assign o_baud_tick             = baud_ff;

    // ---------------- PWM-capable timers ----------------
    always_comb begin
        logic [1:0]  pwm_mode;
        logic [1:0]  run;
        logic [1:0]  set_req;
        logic        step;
        logic [15:0] reload;
        logic [7:0]  sub_last;
        step      = 1'b0;
        reload    = '0;
        sub_last  = '0;
        pwm_mode  = {pctrl_ff[PC_C_MODE], pctrl_ff[PC_B_MODE]};
        run       = {pctrl_ff[PC_C_RUN],  pctrl_ff[PC_B_RUN]};
        set_req   = '0;
        nxt_pctrl = pctrl_ff;
        nxt_req   = req_ff;
        for (int n = 0; n < 2; n++) begin
            nxt_pre[n]  = pre_ff[n];
            nxt_duty[n] = duty_ff[n];
            reload   = {pre_ff[n], duty_ff[n]};
            // Timer mode: fixed 255-clock pre-stage; PWM: prescale+1
            sub_last = pwm_mode[n] ? pre_ff[n] : SUBSTEP_LAST;
            step     = (sub_ff[n] == sub_last);
            nxt_sub[n] = step ? '0 : sub_ff[n] + 8'h1;
            nxt_cnt[n] = cnt_ff[n];
            nxt_lvl[n] = 1'b0;
            if (!run[n]) begin
                // Timer mode held preloaded so the first interval is a full one; PWM mode held at zero
                nxt_sub[n] = '0;
                nxt_cnt[n] = pwm_mode[n] ? '0 : reload;
            end else if (pwm_mode[n]) begin
                // Low byte of the counter is the substep index
                if (step) begin
                    nxt_cnt[n] = (cnt_ff[n][7:0] == SUBSTEP_LAST)
                               ? '0 : cnt_ff[n] + 16'h1;
                end
                nxt_lvl[n] = (cnt_ff[n][7:0] < duty_ff[n]);
            end else if (step) begin
                if (cnt_ff[n] == '0) begin
                    nxt_cnt[n] = reload;
                    set_req[n] = 1'b1;
                end else begin
                    nxt_cnt[n] = cnt_ff[n] - 16'h1;
                end
            end
            // Pin turns output in PWM mode whatever the run bit says
            nxt_oe[n] = pwm_mode[n] | i_port_three_direction[n];
        end
        if (wr_go) begin
            unique case (idx)
                IDX_PWM_CTRL:  nxt_pctrl   = wbyte[3:0] & PC_WR_MASK[3:0];
                IDX_B_PRE:     nxt_pre[0]  = wbyte;
                IDX_C_PRE:     nxt_pre[1]  = wbyte;
                IDX_B_DUTY:    nxt_duty[0] = wbyte;
                IDX_C_DUTY:    nxt_duty[1] = wbyte;
                // Writing zero clears; writing one leaves the flag
                IDX_PWM_FLAGS: nxt_req     = req_ff & wbyte[1:0];
                default: ;
            endcase
        end
        nxt_req = nxt_req | set_req;
    end

    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            pctrl_ff <= '0;
            req_ff   <= '0;
            lvl_ff   <= '0;
            oe_ff    <= '0;
            for (int n = 0; n < 2; n++) begin
                pre_ff[n]  <= '0;
                duty_ff[n] <= '0;
                sub_ff[n]  <= '0;
                cnt_ff[n]  <= '0;
            end
        end else begin
            pctrl_ff <= nxt_pctrl;
            req_ff   <= nxt_req;
            lvl_ff   <= nxt_lvl;
            oe_ff    <= nxt_oe;
            for (int n = 0; n < 2; n++) begin
                pre_ff[n]  <= nxt_pre[n];
                duty_ff[n] <= nxt_duty[n];
                sub_ff[n]  <= nxt_sub[n];
                cnt_ff[n]  <= nxt_cnt[n];
            end
        end
    end

    // Index 0 is port three bit 4, index 1 is bit 5
    assign o_pwm_pins.level        = lvl_ff;
    assign o_pwm_pins.oe           = oe_ff;
    assign o_pwm_interrupt_request = req_ff;

endmodule : tcpu_timer_pwm

// ---- verification/tcpu_monitor.sv ----
// Port-level assertions for the timer, counter and PWM unit
module tcpu_monitor
    import tcpu_pkg::*;
(
    // Clock and reset
    input wire logic           i_mclk,
    input wire logic           i_nrst,
    // Observed ports
    input wire tcpu_avs_req_t  i_avs,
    input wire logic [31:0]    o_avs_readdata,
    input wire logic           o_avs_waitrequest,
    input wire logic [1:0]     i_port_three_direction,
    input wire tcpu_pwm_pins_t o_pwm_pins,
    input wire logic [1:0]     o_legacy_overflow_flags,
    input wire logic [1:0]     o_pwm_interrupt_request,
    input wire logic           o_baud_tick
);
    logic       wr_ok;
    logic [7:0] widx;
    assign wr_ok = i_avs.write && !o_avs_waitrequest && i_avs.byteenable[0];
    assign widx  = i_avs.address[9:2];
    default clocking @(posedge i_mclk); endclocking
    default disable iff (!i_nrst);
    bus_wait_a: assert property ($rose(i_avs.read || i_avs.write)
        |-> o_avs_waitrequest ##1 !o_avs_waitrequest) else $error("bus wait");
    ctrl_reserved_a: assert property (i_avs.read && !o_avs_waitrequest
        && widx == IDX_PWM_CTRL |-> o_avs_readdata[7:4] == 4'h0)
        else $error("reserved bits");
    req_clear_a: assert property ($fell(o_pwm_interrupt_request[0])
        |-> $past(wr_ok && widx == IDX_PWM_FLAGS && !i_avs.writedata[0]))
        else $error("request dropped");
    flag_clear_a: assert property ($fell(o_legacy_overflow_flags[1])
        |-> $past(wr_ok && widx == IDX_LEG_CTRL && !i_avs.writedata[7]))
        else $error("flag dropped");
    baud_pulse_a: assert property (o_baud_tick |=> !o_baud_tick)
        else $error("baud tick long");
    pwm_quiet_a: assert property ($rose(o_pwm_interrupt_request[1])
        |-> !$past(o_pwm_pins.oe[1] && !i_port_three_direction[1]))
        else $error("request in pwm");
    dir_pass_a: assert property ($past(i_nrst)
        && $past(i_port_three_direction[1]) |-> o_pwm_pins.oe[1])
        else $error("direction lost");
    pin_drive_a: assert property ($rose(o_pwm_pins.level[0])
        |-> ##[0:1] o_pwm_pins.oe[0]) else $error("level undriven");
endmodule : tcpu_monitor

bind tcpu_timer_pwm tcpu_monitor i_tcpu_monitor (.i_mclk, .i_nrst, .i_avs,
    .o_avs_readdata, .o_avs_waitrequest, .i_port_three_direction,
    .o_pwm_pins, .o_legacy_overflow_flags, .o_pwm_interrupt_request,
    .o_baud_tick);

// ---- verification/tcpu_pin_model.sv ----
// Core-side pin model: count pins, gate pins, direction bits
module tcpu_pin_model (
    // Clock
    input  wire logic  i_mclk,
    // Pins toward the timer block
    output logic       o_cnt_a,
    output logic       o_cnt_b,
    output logic       o_ext_a_n,
    output logic       o_ext_b_n,
    output logic [1:0] o_dir
);
    timeunit 1ns;
    timeprecision 1ps;
    // Pins idle high, as the port pull-ups leave them
    initial begin
        {o_cnt_a, o_cnt_b, o_ext_a_n, o_ext_b_n} = 4'hF;
        o_dir = 2'h0;
    end
    // Four clocks per level so the three-stage sync sees every edge
    task automatic pulses(input int n);
        repeat (n) begin
            o_cnt_a <= 1'b0;
            repeat (4) @(posedge i_mclk);
            o_cnt_a <= 1'b1;
            repeat (4) @(posedge i_mclk);
        end
    endtask : pulses
    task automatic set_pins(input logic gate_n, input logic [1:0] d);
        o_ext_a_n <= gate_n;
        o_dir     <= d;
        @(posedge i_mclk);
    endtask : set_pins
endmodule : tcpu_pin_model

// ---- verification/testbench.sv ----
// Self-checking bench for the timer, counter and PWM unit
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import tcpu_pkg::*;
    logic           mclk;
    logic           nrst;
    tcpu_avs_req_t  avs;
    logic [31:0]    rdata;
    logic           wreq;
    logic           cnt_a;
    logic           cnt_b;
    logic           ext_a_n;
    logic           ext_b_n;
    logic [1:0]     dir;
    tcpu_pwm_pins_t pins;
    logic [1:0]     preq;
    logic [1:0]     lflags;
    logic           baud;
    int             failures = 0;
    int             total_checks = 0;
    int             cyc = 0;
    tcpu_timer_pwm i_tcpu_timer_pwm (
        .i_mclk                       (mclk),
        .i_nrst                       (nrst),
        .i_avs                        (avs),
        .o_avs_readdata               (rdata),
        .o_avs_waitrequest            (wreq),
        .i_legacy_timer_a_count_input (cnt_a),
        .i_legacy_timer_b_count_input (cnt_b),
        .i_external_interrupt_a_pin_n (ext_a_n),
        .i_external_interrupt_b_pin_n (ext_b_n),
        .i_port_three_direction       (dir),
        .o_pwm_pins                   (pins),
        .o_legacy_overflow_flags      (lflags),
        .o_pwm_interrupt_request      (preq),
        .o_baud_tick                  (baud)
    );
    tcpu_pin_model i_tcpu_pin_model (.i_mclk(mclk), .o_cnt_a(cnt_a),
        .o_cnt_b(cnt_b), .o_ext_a_n(ext_a_n), .o_ext_b_n(ext_b_n),
        .o_dir(dir));
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end
    always @(posedge mclk) cyc <= cyc + 1;
    task automatic complete_run();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : complete_run
    task automatic miss(input string m);
        failures++;
        $display("MISMATCH %0t %s", $time, m);
    endtask : miss
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) miss($sformatf("got %h exp %h", got, exp));
    endtask : chk8
    task automatic chkn(input int got, input int exp, input int tol);
        total_checks++;
        if (got < exp - tol || got > exp + tol)
            miss($sformatf("count %0d exp %0d", got, exp));
    endtask : chkn
    // Held until waitrequest is seen low; one spare edge between requests
    task automatic bus(input logic w, input logic [7:0] idx,
                       input logic [7:0] wd, output logic [7:0] rd);
        int n = 0;
        avs <= '{!w, w, {idx, 2'b00}, {24'h0, wd}, 4'h1};
        @(posedge mclk);
        while (wreq !== 1'b0) begin
            if (++n > 16) begin
                miss("bus hang");
                complete_run();
            end
            @(posedge mclk);
        end
        rd = rdata[7:0];
        avs <= '0;
        @(posedge mclk);
    endtask : bus
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        logic [7:0] x;
        bus(1'b1, idx, d, x);
    endtask : wr
    task automatic rc(input logic [7:0] idx, input logic [7:0] exp);
        logic [7:0] x;
        bus(1'b0, idx, 8'h00, x);
        chk8(x, exp);
    endtask : rc
    task automatic wait_req(input int t, input int lim);
        int n = 0;
        while (preq[t] !== 1'b1) begin
            if (++n > lim) begin
                miss("no request");
                complete_run();
            end
            @(posedge mclk);
        end
    endtask : wait_req
    task automatic t_timer(input int t, input int pre, input int lo,
                           input int n);
        int t0;
        int exp = 255 * (pre * 256 + lo + 1);
        wr(IDX_B_PRE + 8'(t), 8'(pre));
        wr(IDX_B_DUTY + 8'(t), 8'(lo));
        wr(IDX_PWM_CTRL, 8'(2 << (2 * t)));
        t0 = cyc;
        repeat (n) begin
            wait_req(t, exp + 8);
            chkn(cyc - t0, exp, 3);
            t0 = cyc;
            wr(IDX_PWM_FLAGS, 8'(~(1 << t) & 3));
        end
        wr(IDX_PWM_CTRL, 8'h00);
    endtask : t_timer
    task automatic t_pwm(input int t, input int pre, input int duty);
        int hi = 0;
        wr(IDX_B_PRE + 8'(t), 8'(pre));
        wr(IDX_B_DUTY + 8'(t), 8'(duty));
        wr(IDX_PWM_CTRL, 8'(3 << (2 * t)));
        repeat (300) @(posedge mclk);
        repeat (255 * (pre + 1)) begin
            @(posedge mclk);
            hi += int'(pins.level[t] === 1'b1);
        end
        chkn(hi, duty * (pre + 1), 0);
        chk8({7'h0, pins.oe[t]}, 8'h01);
        chk8({6'h0, preq}, 8'h00);
        wr(IDX_PWM_CTRL, 8'h00);
    endtask : t_pwm
    task automatic t_legacy();
        int nb = 0;
        wr(IDX_A_LOW, 8'hFE);
        wr(IDX_A_HIGH, 8'hFF);
        wr(IDX_LEG_MODE, 8'h01);
        wr(IDX_CLK_RATE, 8'h19);
        wr(IDX_LEG_CTRL, 8'h10);
        repeat (12) @(posedge mclk);
        rc(IDX_A_HIGH, 8'h00);
        rc(IDX_LEG_CTRL, 8'h30);
        chk8({6'h0, lflags}, 8'h01);
        wr(IDX_B_HIGH, 8'hF0);
        wr(IDX_B_LOW, 8'hFE);
        wr(IDX_LEG_MODE, 8'h20);
        wr(IDX_LEG_CTRL, 8'h40);
        repeat (24) begin
            @(posedge mclk);
            nb += int'(baud === 1'b1);
        end
        chkn(nb, 1, 0);
        rc(IDX_B_HIGH, 8'hF0);
        rc(IDX_LEG_CTRL, 8'hC0);
        wr(IDX_LEG_CTRL, 8'h00);
        wr(IDX_A_LOW, 8'h55);
        wr(IDX_A_HIGH, 8'hFE);
        wr(IDX_B_LOW, 8'h12);
        wr(IDX_LEG_MODE, 8'h33);
        wr(IDX_LEG_CTRL, 8'h40);
        repeat (24) @(posedge mclk);
        rc(IDX_LEG_CTRL, 8'hC0);
        chk8({6'h0, lflags}, 8'h02);
        rc(IDX_A_LOW, 8'h55);
        rc(IDX_B_LOW, 8'h12);
        wr(IDX_LEG_CTRL, 8'h00);
        wr(IDX_A_LOW, 8'h00);
        wr(IDX_LEG_MODE, 8'h0D);
        wr(IDX_LEG_CTRL, 8'h10);
        i_tcpu_pin_model.set_pins(1'b0, 2'h0);
        i_tcpu_pin_model.pulses(3);
        rc(IDX_A_LOW, 8'h00);
        i_tcpu_pin_model.set_pins(1'b1, 2'h0);
        i_tcpu_pin_model.pulses(3);
        repeat (4) @(posedge mclk);
        rc(IDX_A_LOW, 8'h03);
        wr(IDX_LEG_CTRL, 8'h00);
    endtask : t_legacy
    initial begin
        nrst = 1'b0;
        avs = '0;
        repeat (8) @(posedge mclk);
        nrst <= 1'b1;
        @(posedge mclk);
        rc(IDX_CLK_RATE, 8'h01);
        for (int i = 0; i < 5; i++) rc(IDX_PWM_CTRL + 8'(i), 8'h00);
        wr(IDX_PWM_CTRL, 8'hF0);
        rc(IDX_PWM_CTRL, 8'h00);
        wr(8'h00, 8'h5A);
        rc(8'h00, 8'h00);
        t_legacy();
        t_timer(0, 0, 2, 2);
        t_timer(0, 0, 2, 1);
        t_timer(1, 1, 0, 1);
        t_pwm(0, 0, 0);
        t_pwm(0, 0, 64);
        t_pwm(0, 1, 255);
        t_pwm(1, 1, 128);
        i_tcpu_pin_model.set_pins(1'b1, 2'h3);
        repeat (3) @(posedge mclk);
        chk8({6'h0, pins.oe}, 8'h03);
        complete_run();
    end
endmodule : testbench
